// *** include/ext_bus_pkg.sv ***
// constants and types for the dual external bus port
// assumes a single 200 MHz clock and a synchronous active-low reset
package ext_bus_pkg;

  // ********************************
  // widths
  // ********************************
  localparam int PRI_ADDR_W = 24;
  localparam int EXP_ADDR_W = 13;
  localparam int DATA_W     = 32;
  localparam int FLAG_W     = 2;

  // ********************************
  // pin levels
  // ********************************
  localparam logic EN_ON     = 1'b0;
  localparam logic EN_OFF    = 1'b1;
  localparam logic RW_READ   = 1'b1;
  localparam logic RW_WRITE  = 1'b0;
  localparam logic STB_IDLE  = 1'b1;
  localparam logic FLAG_GPIO = 1'b0;
  localparam logic FLAG_LOCK = 1'b1;

  // ********************************
  // reset values
  // ********************************
  localparam logic [PRI_ADDR_W-1:0] RESET_VECTOR_ADDR = 24'h000000;
  localparam logic [PRI_ADDR_W-1:0] PRI_ADDR_RST      = 24'h000000;
  localparam logic [EXP_ADDR_W-1:0] EXP_ADDR_RST      = 13'h0000;
  localparam logic [DATA_W-1:0]     DATA_RST          = 32'h00000000;
  localparam logic [FLAG_W-1:0]     FLAG_RST          = 2'h3;

  // ********************************
  // flag pin bits in interlock mode
  // ********************************
  localparam int FLAG_LOCK_OUT = 0;
  localparam int FLAG_LOCK_IN  = 1;

  // ********************************
  // state machines
  // ********************************
  typedef enum logic [1:0] {
    pri_boot,
    pri_idle,
    pri_access,
    pri_hold
  } pri_state_t;

  typedef enum logic {
    exp_idle,
    exp_access
  } exp_state_t;

endpackage

// *** testbench/bus_responder.sv ***
// responder model on one bus port: memory or peripheral with wait states
// assumes active-low strobe and ready; read data valid while ready is low
`timescale 1ns/1ps
module bus_responder #(
  parameter int AW = 24
) (
  // bus side
  input  wire logic          clk_i,
  input  wire logic          strobe_n_i,
  input  wire logic          rw_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [31:0]   data_i,
  // control and observation
  input  wire logic [3:0]    wait_i,
  output logic               ready_n_o,
  output logic      [31:0]   data_o,
  output logic      [31:0]   last_wdata_o
);
  // ********
  // responder
  // ********
  logic [3:0]  cnt = 4'h0;
  logic [31:0] word;
  assign word = 32'hC0DE0000 ^ 32'(addr_i);
  assign ready_n_o = strobe_n_i | (cnt < wait_i);
  // idle bus shows the inverse, so a stale word never passes
  assign data_o = ready_n_o ? ~word : word;
  always @(posedge clk_i) begin
    cnt <= strobe_n_i ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
    if (!strobe_n_i && !rw_i && !ready_n_o) last_wdata_o <= data_i;
  end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the dual external bus port
// assumes responder models on both ports; the bench acts as core and bus master
`timescale 1ns/1ps
module tb_top;
  // ********
  // signals
  // ********
  typedef struct packed {
    logic        x;
    logic        wr;
    logic        io;
    logic [23:0] a;
    logic [31:0] d;
    logic [3:0]  wt;
  } row_t;
  logic        clk_i, rst_b_i, pri_req_i, pri_write_i, ignore_bus_request_bit_i, exp_req_i, exp_write_i;
  logic        exp_io_i, interrupt_ack_out_n_exec_i, lock_req_i, pri_ready_n_i, bus_request_n_i, expansion_ready_in_n_i;
  logic        float_all_pins_n_i, pri_busy_o, pri_done_o, boot_vector_valid_o, exp_busy_o, exp_done_o;
  logic        pri_data_en_n_o, pri_rw_o, pri_addr_en_n_o, primary_access_strobe_n_o, pri_strobe_en_n_o;
  logic        bus_grant_ack_n_o, bus_grant_ack_en_n_o, exp_data_en_n_o, expansion_read_not_write_o;
  logic        exp_addr_en_n_o, expansion_memory_strobe_n_o, expansion_io_strobe_n_o, exp_strobe_en_n_o;
  logic        interrupt_ack_out_n_o, interrupt_ack_out_n_en_n_o;
  logic [23:0] pri_addr_i, pri_addr_o;
  logic [12:0] exp_addr_i, exp_addr_o;
  logic [31:0] pri_wdata_i, pri_rdata_o, exp_wdata_i, exp_rdata_o, pri_data_i, pri_data_o;
  logic [31:0] exp_data_i, exp_data_o, prd, xrd, plw, xlw;
  logic [1:0]  flag_mode_i, flag_dir_i, flag_out_i, flag_in_o, external_flag_pins_i;
  logic [1:0]  external_flag_pins_o, external_flag_pins_en_n_o, fl;
  logic [3:0]  pw, xw;
  int          bad_count = 0, comparisons = 0, cyc = 0;
  row_t        rows [7] = '{
    '{1'h0, 1'h0, 1'h0, 24'h000010, 32'h00000000, 4'h0},
    '{1'h0, 1'h1, 1'h0, 24'h000020, 32'h12345678, 4'h3},
    '{1'h0, 1'h0, 1'h0, 24'hFFFFFF, 32'h00000000, 4'h6},
    '{1'h1, 1'h0, 1'h0, 24'h001FFF, 32'h00000000, 4'h0},
    '{1'h1, 1'h1, 1'h1, 24'h000001, 32'hA5A5A5A5, 4'h4},
    '{1'h1, 1'h0, 1'h1, 24'h000AAA, 32'h00000000, 4'h2},
    '{1'h1, 1'h1, 1'h0, 24'h000555, 32'h0F0F0F0F, 4'h0}};
  // ********
  // pins, models and design
  // ********
  assign pri_data_i = pri_data_en_n_o ? prd : pri_data_o;
  assign exp_data_i = exp_data_en_n_o ? xrd : exp_data_o;
  assign external_flag_pins_i = (external_flag_pins_en_n_o & fl) | (~external_flag_pins_en_n_o & external_flag_pins_o);
  ext_bus_port dut (.*);
  bus_responder #(.AW(24)) pri_mem (.clk_i, .strobe_n_i(primary_access_strobe_n_o), .rw_i(pri_rw_o),
    .addr_i(pri_addr_o), .data_i(pri_data_i), .wait_i(pw), .ready_n_o(pri_ready_n_i), .data_o(prd),
    .last_wdata_o(plw));
  bus_responder #(.AW(13)) exp_mem (.clk_i, .strobe_n_i(expansion_memory_strobe_n_o & expansion_io_strobe_n_o),
    .rw_i(expansion_read_not_write_o), .addr_i(exp_addr_o), .data_i(exp_data_i), .wait_i(xw),
    .ready_n_o(expansion_ready_in_n_i), .data_o(xrd), .last_wdata_o(xlw));
  // ********
  // tasks
  // ********
  function automatic logic [31:0] word(input logic [23:0] a);
    return 32'hC0DE0000 ^ {8'h00, a};
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one access; bus request drops at wait cycle hold
  task automatic acc(input row_t r, input int hold);
    int n;
    @(negedge clk_i);
    {pw, xw, pri_write_i, exp_write_i, exp_io_i} = {r.wt, r.wt, r.wr, r.wr, r.io};
    {pri_addr_i, exp_addr_i, pri_wdata_i, exp_wdata_i} = {r.a, r.a[12:0], r.d, r.d};
    {pri_req_i, exp_req_i} = {!r.x, r.x};
    @(negedge clk_i);
    {pri_req_i, exp_req_i} = 2'h0;
    @(negedge clk_i);
    chk({primary_access_strobe_n_o, expansion_memory_strobe_n_o, expansion_io_strobe_n_o},
        {r.x, !r.x | r.io, !r.x | !r.io});
    chk(r.x ? expansion_read_not_write_o : pri_rw_o, !r.wr);
    chk(r.x ? 24'(exp_addr_o) : pri_addr_o, r.a);
    n = 1;
    while ((r.x ? exp_done_o : pri_done_o) !== 1'h1 && n < 60) begin
      if (n == hold) bus_request_n_i = 1'h0;
      @(negedge clk_i);
      n++;
    end
    chk(n < 60 && n >= 3 + r.wt, 1'h1);
    chk(r.wr ? (r.x ? xlw : plw) : (r.x ? exp_rdata_o : pri_rdata_o), r.wr ? r.d : word(r.a));
  endtask
  // ********
  // run
  // ********
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    {pri_req_i, pri_write_i, exp_req_i, exp_write_i, exp_io_i, interrupt_ack_out_n_exec_i, lock_req_i} = 7'h00;
    {ignore_bus_request_bit_i, rst_b_i, bus_request_n_i, float_all_pins_n_i} = 4'h3;
    {pri_addr_i, exp_addr_i, pri_wdata_i, exp_wdata_i, flag_mode_i, flag_dir_i, flag_out_i} = '0;
    {fl, pw, xw} = {2'h3, 4'h2, 4'h0};
    repeat (6) @(negedge clk_i);
    chk({pri_busy_o, exp_busy_o, pri_addr_en_n_o, pri_data_en_n_o, exp_data_en_n_o,
         external_flag_pins_en_n_o}, 7'h5F);
    rst_b_i = 1'h1;
    while (boot_vector_valid_o !== 1'h1 && cyc < 100) @(negedge clk_i);
    chk({pri_addr_o, pri_rdata_o}, {ext_bus_pkg::RESET_VECTOR_ADDR, word(ext_bus_pkg::RESET_VECTOR_ADDR)});
    foreach (rows[i]) acc(rows[i], 99);
    // bus request arrives mid access, then a refused core request
    acc(row_t'{1'h0, 1'h0, 1'h0, 24'h000100, 32'h00000000, 4'h6}, 3);
    chk(bus_grant_ack_n_o, 1'h1);
    pri_req_i = 1'h1;
    @(negedge clk_i);
    pri_req_i = 1'h0;
    repeat (5) @(negedge clk_i);
    chk({bus_grant_ack_n_o, pri_addr_en_n_o, pri_data_en_n_o, pri_strobe_en_n_o, primary_access_strobe_n_o,
         pri_busy_o}, 6'h1F);
    bus_request_n_i = 1'h1;
    repeat (5) @(negedge clk_i);
    chk({bus_grant_ack_n_o, pri_addr_en_n_o, pri_busy_o}, 3'h4);
    {ignore_bus_request_bit_i, bus_request_n_i} = 2'h2;
    repeat (5) @(negedge clk_i);
    chk(bus_grant_ack_n_o, 1'h1);
    acc(rows[0], 99);
    {ignore_bus_request_bit_i, bus_request_n_i} = 2'h1;
    interrupt_ack_out_n_exec_i = 1'h1;
    @(negedge clk_i);
    interrupt_ack_out_n_exec_i = 1'h0;
    chk({interrupt_ack_out_n_en_n_o, interrupt_ack_out_n_o}, 2'h0);
    @(negedge clk_i);
    chk(interrupt_ack_out_n_o, 1'h1);
    {flag_dir_i, flag_out_i} = 4'h4;
    repeat (4) @(negedge clk_i);
    chk({external_flag_pins_en_n_o, external_flag_pins_i, flag_in_o}, 6'h2A);
    {flag_mode_i, lock_req_i} = 3'h7;
    repeat (4) @(negedge clk_i);
    chk({external_flag_pins_en_n_o, external_flag_pins_i}, 4'hA);
    float_all_pins_n_i = 1'h0;
    repeat (4) @(negedge clk_i);
    chk({pri_addr_en_n_o, exp_addr_en_n_o, pri_strobe_en_n_o, exp_strobe_en_n_o, bus_grant_ack_en_n_o,
         interrupt_ack_out_n_en_n_o, external_flag_pins_en_n_o}, 8'hFF);
    finish_test;
  end
endmodule

// *** verilog/ext_bus_port.sv ***
// primary and expansion external bus logic of the processor
// assumes a core that pulses requests while busy is low
// Notes on behaviour
// - primary port has 32-bit two-way data and 24-bit output address, both floatable.
// - primary read/write is high for reads, low for writes.
// - one active-low strobe marks each primary access.
// - primary access completes only after the responder signals ready.
// - a bus request waits until the running primary access ends.
// - while granted, primary address, data and strobe float (read/write stays driven) and no new access starts.
// - primary accesses resume when request goes high or ignore bit is set.
// - acknowledge goes low in answer to a low bus request.
// - acknowledge is high while request is high or ignore bit is set.
// - expansion port has 32-bit two-way floatable data.
// - expansion port has 13-bit floatable output address.
// - expansion read/write is high for reads, low for writes.
// - memory strobe marks expansion memory accesses.
// - separate I/O strobe marks expansion I/O accesses.
// - expansion access completes only after expansion ready.
// - held in reset while low; afterwards fetch from reset vector.
// - interrupt acknowledge pulses low when the acknowledge instruction runs.
// - two flag pins serve as general I/O or interlock signals.
`timescale 1ns/1ps
module ext_bus_port (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_b_i,
  // core side, primary
  input  wire logic                               pri_req_i,
  input  wire logic                               pri_write_i,
  input  wire logic [ext_bus_pkg::PRI_ADDR_W-1:0] pri_addr_i,
  input  wire logic [ext_bus_pkg::DATA_W-1:0]     pri_wdata_i,
  input  wire logic                               ignore_bus_request_bit_i,
  output logic                                    pri_busy_o,
  output logic                                    pri_done_o,
  output logic      [ext_bus_pkg::DATA_W-1:0]     pri_rdata_o,
  output logic                                    boot_vector_valid_o,
  // core side, expansion
  input  wire logic                               exp_req_i,
  input  wire logic                               exp_write_i,
  input  wire logic                               exp_io_i,
  input  wire logic [ext_bus_pkg::EXP_ADDR_W-1:0] exp_addr_i,
  input  wire logic [ext_bus_pkg::DATA_W-1:0]     exp_wdata_i,
  output logic                                    exp_busy_o,
  output logic                                    exp_done_o,
  output logic      [ext_bus_pkg::DATA_W-1:0]     exp_rdata_o,
  // core side, control
  input  wire logic                               interrupt_ack_out_n_exec_i,
  input  wire logic [ext_bus_pkg::FLAG_W-1:0]     flag_mode_i,
  input  wire logic [ext_bus_pkg::FLAG_W-1:0]     flag_dir_i,
  input  wire logic [ext_bus_pkg::FLAG_W-1:0]     flag_out_i,
  input  wire logic                               lock_req_i,
  output logic      [ext_bus_pkg::FLAG_W-1:0]     flag_in_o,
  // primary pins
  input  wire logic [ext_bus_pkg::DATA_W-1:0]     pri_data_i,
  output logic      [ext_bus_pkg::DATA_W-1:0]     pri_data_o,
  output logic                                    pri_data_en_n_o,
  output logic      [ext_bus_pkg::PRI_ADDR_W-1:0] pri_addr_o,
  output logic                                    pri_rw_o,
  output logic                                    pri_addr_en_n_o,
  output logic                                    primary_access_strobe_n_o,
  output logic                                    pri_strobe_en_n_o,
  input  wire logic                               pri_ready_n_i,
  input  wire logic                               bus_request_n_i,
  output logic                                    bus_grant_ack_n_o,
  output logic                                    bus_grant_ack_en_n_o,
  // expansion pins
  input  wire logic [ext_bus_pkg::DATA_W-1:0]     exp_data_i,
  output logic      [ext_bus_pkg::DATA_W-1:0]     exp_data_o,
  output logic                                    exp_data_en_n_o,
  output logic      [ext_bus_pkg::EXP_ADDR_W-1:0] exp_addr_o,
  output logic                                    expansion_read_not_write_o,
  output logic                                    exp_addr_en_n_o,
  output logic                                    expansion_memory_strobe_n_o,
  output logic                                    expansion_io_strobe_n_o,
  output logic                                    exp_strobe_en_n_o,
  input  wire logic                               expansion_ready_in_n_i,
  // control pins
  input  wire logic                               float_all_pins_n_i,
  output logic                                    interrupt_ack_out_n_o,
  output logic                                    interrupt_ack_out_n_en_n_o,
  input  wire logic [ext_bus_pkg::FLAG_W-1:0]     external_flag_pins_i,
  output logic      [ext_bus_pkg::FLAG_W-1:0]     external_flag_pins_o,
  output logic      [ext_bus_pkg::FLAG_W-1:0]     external_flag_pins_en_n_o
);

  // ********************************
  // helpers
  // ********************************
  // enable is low only when driving and not floated
  function automatic logic en_n(input logic drive, input logic flt);
    en_n = (drive && !flt) ? ext_bus_pkg::EN_ON : ext_bus_pkg::EN_OFF;
  endfunction

  // ********************************
  // pin synchronisers
  // ********************************
  localparam int SW = 4 + ext_bus_pkg::FLAG_W + 2 * ext_bus_pkg::DATA_W;

  logic                           s_pri_ready_n;
  logic                           s_bus_req_n;
  logic                           s_float_n;
  logic                           s_exp_ready_n;
  logic [ext_bus_pkg::FLAG_W-1:0] s_flags;
  logic [ext_bus_pkg::DATA_W-1:0] s_pri_data;
  logic [ext_bus_pkg::DATA_W-1:0] s_exp_data;

  // data passes the same two stages as ready, so they line up
  pin_sync #(.W(SW)) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({pri_ready_n_i, bus_request_n_i, float_all_pins_n_i,
               expansion_ready_in_n_i, external_flag_pins_i,
               pri_data_i, exp_data_i}),
    .q_o     ({s_pri_ready_n, s_bus_req_n, s_float_n, s_exp_ready_n,
               s_flags, s_pri_data, s_exp_data})
  );

  wire flt = !s_float_n;

  // ********************************
  // primary port
  // ********************************
  ext_bus_pkg::pri_state_t pri_state;
  ext_bus_pkg::pri_state_t next_pri_state;
  logic                    pri_write;
  logic                    pri_boot_acc;

  wire hold_active = !s_bus_req_n && !ignore_bus_request_bit_i;
  wire pri_fin     = (pri_state == ext_bus_pkg::pri_access) && !s_pri_ready_n;
  wire pri_take    = (pri_state == ext_bus_pkg::pri_idle) && !hold_active
                     && pri_req_i;
  wire pri_drive   = (next_pri_state != ext_bus_pkg::pri_hold);

  always_comb begin
    next_pri_state = pri_state;
    case (pri_state)
      ext_bus_pkg::pri_boot: begin
        next_pri_state = ext_bus_pkg::pri_access;
      end
      ext_bus_pkg::pri_idle: begin
        if (hold_active) begin
          next_pri_state = ext_bus_pkg::pri_hold;
        end else if (pri_req_i) begin
          next_pri_state = ext_bus_pkg::pri_access;
        end
      end
      ext_bus_pkg::pri_access: begin
        if (pri_fin) begin
          next_pri_state = ext_bus_pkg::pri_idle;
        end
      end
      ext_bus_pkg::pri_hold: begin
        if (!hold_active) begin
          next_pri_state = ext_bus_pkg::pri_idle;
        end
      end
      default: begin
        next_pri_state = ext_bus_pkg::pri_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pri_state    <= ext_bus_pkg::pri_boot;
      pri_boot_acc <= 1'b1;
      pri_write    <= ext_bus_pkg::RW_WRITE;
      pri_addr_o   <= ext_bus_pkg::PRI_ADDR_RST;
      pri_data_o   <= ext_bus_pkg::DATA_RST;
    end else begin
      pri_state <= next_pri_state;
      if (pri_fin) begin
        pri_boot_acc <= 1'b0;
      end
      if (pri_state == ext_bus_pkg::pri_boot) begin
        pri_write  <= 1'b0;
        pri_addr_o <= ext_bus_pkg::RESET_VECTOR_ADDR;
      end else if (pri_take) begin
        pri_write  <= pri_write_i;
        pri_addr_o <= pri_addr_i;
        pri_data_o <= pri_wdata_i;
      end
    end
  end

  wire next_pri_rw  = (pri_take ? pri_write_i : pri_write)
                      ? ext_bus_pkg::RW_WRITE : ext_bus_pkg::RW_READ;
  wire next_pri_stb = (next_pri_state == ext_bus_pkg::pri_access)
                      ? !ext_bus_pkg::STB_IDLE : ext_bus_pkg::STB_IDLE;
  wire next_pri_den = en_n(next_pri_stb != ext_bus_pkg::STB_IDLE
                           && next_pri_rw == ext_bus_pkg::RW_WRITE, flt);
  wire next_pri_aen = en_n(pri_drive, flt);
  wire next_ack     = !(next_pri_state == ext_bus_pkg::pri_hold);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pri_rw_o                  <= ext_bus_pkg::RW_READ;
      primary_access_strobe_n_o <= ext_bus_pkg::STB_IDLE;
      pri_data_en_n_o           <= ext_bus_pkg::EN_OFF;
      pri_addr_en_n_o           <= ext_bus_pkg::EN_OFF;
      pri_strobe_en_n_o         <= ext_bus_pkg::EN_ON;
      bus_grant_ack_n_o         <= 1'b1;
      bus_grant_ack_en_n_o      <= ext_bus_pkg::EN_ON;
      pri_busy_o                <= 1'b1;
      pri_done_o                <= 1'b0;
      boot_vector_valid_o       <= 1'b0;
      pri_rdata_o               <= ext_bus_pkg::DATA_RST;
    end else begin
      pri_rw_o                  <= next_pri_rw;
      primary_access_strobe_n_o <= next_pri_stb;
      pri_data_en_n_o           <= next_pri_den;
      pri_addr_en_n_o           <= next_pri_aen;
      pri_strobe_en_n_o         <= next_pri_aen;
      bus_grant_ack_n_o         <= next_ack;
      bus_grant_ack_en_n_o      <= en_n(1'b1, flt);
      pri_busy_o                <= (next_pri_state != ext_bus_pkg::pri_idle);
      pri_done_o                <= pri_fin && !pri_boot_acc;
      boot_vector_valid_o       <= pri_fin && pri_boot_acc;
      if (pri_fin) begin
        pri_rdata_o <= s_pri_data;
      end
    end
  end

  // ********************************
  // expansion port
  // ********************************
  ext_bus_pkg::exp_state_t exp_state;
  ext_bus_pkg::exp_state_t next_exp_state;
  logic                    exp_write;
  logic                    exp_io;

  wire exp_fin  = (exp_state == ext_bus_pkg::exp_access) && !s_exp_ready_n;
  wire exp_take = (exp_state == ext_bus_pkg::exp_idle) && exp_req_i;

  always_comb begin
    next_exp_state = exp_state;
    case (exp_state)
      ext_bus_pkg::exp_idle: begin
        if (exp_req_i) begin
          next_exp_state = ext_bus_pkg::exp_access;
        end
      end
      ext_bus_pkg::exp_access: begin
        if (exp_fin) begin
          next_exp_state = ext_bus_pkg::exp_idle;
        end
      end
      default: begin
        next_exp_state = ext_bus_pkg::exp_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      exp_state  <= ext_bus_pkg::exp_idle;
      exp_write  <= 1'b0;
      exp_io     <= 1'b0;
      exp_addr_o <= ext_bus_pkg::EXP_ADDR_RST;
      exp_data_o <= ext_bus_pkg::DATA_RST;
    end else begin
      exp_state <= next_exp_state;
      if (exp_take) begin
        exp_write  <= exp_write_i;
        exp_io     <= exp_io_i;
        exp_addr_o <= exp_addr_i;
        exp_data_o <= exp_wdata_i;
      end
    end
  end

  wire exp_act    = (next_exp_state == ext_bus_pkg::exp_access);
  wire exp_wr_now = exp_take ? exp_write_i : exp_write;
  wire exp_io_now = exp_take ? exp_io_i : exp_io;
  wire next_exp_rw = exp_wr_now ? ext_bus_pkg::RW_WRITE : ext_bus_pkg::RW_READ;
  wire next_mstb   = !(exp_act && !exp_io_now);
  wire next_iostb  = !(exp_act && exp_io_now);
  wire next_exp_den = en_n(exp_act && exp_wr_now, flt);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      expansion_read_not_write_o  <= ext_bus_pkg::RW_READ;
      expansion_memory_strobe_n_o <= ext_bus_pkg::STB_IDLE;
      expansion_io_strobe_n_o     <= ext_bus_pkg::STB_IDLE;
      exp_data_en_n_o             <= ext_bus_pkg::EN_OFF;
      exp_addr_en_n_o             <= ext_bus_pkg::EN_OFF;
      exp_strobe_en_n_o           <= ext_bus_pkg::EN_ON;
      exp_busy_o                  <= 1'b0;
      exp_done_o                  <= 1'b0;
      exp_rdata_o                 <= ext_bus_pkg::DATA_RST;
    end else begin
      expansion_read_not_write_o  <= next_exp_rw;
      expansion_memory_strobe_n_o <= next_mstb;
      expansion_io_strobe_n_o     <= next_iostb;
      exp_data_en_n_o             <= next_exp_den;
      exp_addr_en_n_o             <= en_n(1'b1, flt);
      exp_strobe_en_n_o           <= en_n(1'b1, flt);
      exp_busy_o                  <= exp_act;
      exp_done_o                  <= exp_fin;
      if (exp_fin) begin
        exp_rdata_o <= s_exp_data;
      end
    end
  end

  // ********************************
  // control pins
  // ********************************
  // per-pin mode select
  logic [ext_bus_pkg::FLAG_W-1:0] next_flag_out;
  logic [ext_bus_pkg::FLAG_W-1:0] next_flag_drv;

  always_comb begin
    next_flag_out = flag_out_i;
    next_flag_drv = flag_dir_i;
    if (flag_mode_i[ext_bus_pkg::FLAG_LOCK_OUT] == ext_bus_pkg::FLAG_LOCK) begin
      next_flag_out[ext_bus_pkg::FLAG_LOCK_OUT] = !lock_req_i;
      next_flag_drv[ext_bus_pkg::FLAG_LOCK_OUT] = 1'b1;
    end
    if (flag_mode_i[ext_bus_pkg::FLAG_LOCK_IN] == ext_bus_pkg::FLAG_LOCK) begin
      next_flag_drv[ext_bus_pkg::FLAG_LOCK_IN] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      interrupt_ack_out_n_o     <= 1'b1;
      interrupt_ack_out_n_en_n_o               <= ext_bus_pkg::EN_ON;
      external_flag_pins_o      <= ext_bus_pkg::FLAG_RST;
      external_flag_pins_en_n_o <= {ext_bus_pkg::FLAG_W{ext_bus_pkg::EN_OFF}};
      flag_in_o                 <= ext_bus_pkg::FLAG_RST;
    end else begin
      interrupt_ack_out_n_o     <= !interrupt_ack_out_n_exec_i;
      interrupt_ack_out_n_en_n_o               <= en_n(1'b1, flt);
      external_flag_pins_o      <= next_flag_out;
      external_flag_pins_en_n_o <= ~next_flag_drv | {ext_bus_pkg::FLAG_W{flt}};
      flag_in_o                 <= s_flags;
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_pri_ready_gate: assert property (
    pri_done_o |-> $past(!s_pri_ready_n, 1) && $past(!primary_access_strobe_n_o, 1))
    else $error("primary access ended without ready");

  a_pri_rw_level: assert property (
    !primary_access_strobe_n_o |-> pri_rw_o == (pri_write ? 1'b0 : 1'b1))
    else $error("primary read/write level wrong");

  a_hold_after_idle: assert property (
    $fell(bus_grant_ack_n_o) |-> $past(primary_access_strobe_n_o, 1))
    else $error("bus granted during an access");

  a_hold_floats: assert property (
    !bus_grant_ack_n_o |-> pri_addr_en_n_o && pri_data_en_n_o
                           && pri_strobe_en_n_o && primary_access_strobe_n_o)
    else $error("primary lines driven while granted");

  a_ignore_ack_high: assert property (
    ignore_bus_request_bit_i ##1 ignore_bus_request_bit_i |-> bus_grant_ack_n_o)
    else $error("acknowledge low with ignore bit set");

  a_hold_ack_grant: assert property (
    !s_bus_req_n && !ignore_bus_request_bit_i && primary_access_strobe_n_o
    && pri_state == ext_bus_pkg::pri_idle |=> !bus_grant_ack_n_o)
    else $error("no acknowledge after bus request");

  a_exp_ready_gate: assert property (
    exp_done_o |-> $past(!s_exp_ready_n, 1))
    else $error("expansion access ended without ready");

  a_exp_strobe_sel: assert property (
    !expansion_io_strobe_n_o |-> exp_io && expansion_memory_strobe_n_o)
    else $error("expansion strobes clash");

  a_exp_rw_level: assert property (
    !expansion_memory_strobe_n_o |-> expansion_read_not_write_o == !exp_write)
    else $error("expansion read/write level wrong");

  a_interrupt_ack_out_n_pulse: assert property (
    interrupt_ack_out_n_exec_i |=> !interrupt_ack_out_n_o)
    else $error("acknowledge pulse missing");

  a_float_all: assert property (
    flt |=> pri_addr_en_n_o && pri_data_en_n_o && exp_data_en_n_o
            && exp_addr_en_n_o && exp_strobe_en_n_o && interrupt_ack_out_n_en_n_o)
    else $error("pin driven while float-all active");

  c_pri_read: cover property (pri_done_o && pri_rw_o == ext_bus_pkg::RW_READ);
  c_bus_grant: cover property (!bus_grant_ack_n_o ##1 bus_grant_ack_n_o);
  c_exp_io_write: cover property (exp_done_o && exp_io && exp_write);
  c_boot_fetch: cover property (boot_vector_valid_o);

endmodule

// *** verilog/pin_sync.sv ***
// two-stage synchroniser for asynchronous pin inputs
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/1ps
module pin_sync #(
  parameter int            W    = 1,
  parameter logic [W-1:0]  INIT = '1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // first stage is read only by the second
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta <= INIT;
      q_o  <= INIT;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule
